// ==== hw/tpmon_cfg.svh ====
// register offsets, field positions, reset values and timing counts of the performance monitor
`ifndef TPMON_CFG_SVH
`define TPMON_CFG_SVH
`define TPMON_OFF_INDEX 8'h0E
`define TPMON_OFF_DATA 8'h0F
`define TPMON_OFF_CTRL 8'hC2
`define TPMON_OFF_IEN_LO 8'hC3
`define TPMON_OFF_IEN_HI 8'hC4
`define TPMON_OFF_FLG_LO 8'hC5
`define TPMON_OFF_FLG_HI 8'hC6
`define TPMON_OFF_STATUS 8'hC7
`define TPMON_OFF_FORMAT 8'hC8
`define TPMON_CTRL_AUTO 0
`define TPMON_CTRL_MANUAL 1
`define TPMON_FMT_J1 2
`define TPMON_BIT_FER 0
`define TPMON_BIT_CRC 1
`define TPMON_BIT_ALIGNMENT_CHANGE_COUNT 2
`define TPMON_BIT_OOF 3
`define TPMON_BIT_PATTERN_RECEIVER_ERROR_COUNT 4
`define TPMON_BIT_DDS 5
`define TPMON_BIT_LCV 0
`define TPMON_ID_CRC_LO 4'h0
`define TPMON_ID_CRC_HI 4'h1
`define TPMON_ID_FER_LO 4'h2
`define TPMON_ID_FER_HI 4'h3
`define TPMON_ID_ALIGNMENT_CHANGE_COUNT 4'h4
`define TPMON_ID_OOF 4'h5
`define TPMON_ID_PATTERN_RECEIVER_ERROR_COUNT_LO 4'h6
`define TPMON_ID_PATTERN_RECEIVER_ERROR_COUNT_HI 4'h7
`define TPMON_ID_LCV_LO 4'h8
`define TPMON_ID_LCV_HI 4'h9
`define TPMON_ID_DDS_LO 4'hA
`define TPMON_ID_DDS_HI 4'hB
`define TPMON_RESET_BYTE 8'h00
`define TPMON_CLK_HZ 40000000
`define TPMON_PERIOD_S 1
`define TPMON_PERIOD_CYC (`TPMON_CLK_HZ * `TPMON_PERIOD_S)
`endif

// ==== hw/tpmon_pkg.sv ====
// types shared by the performance monitor
package tpmon_pkg;
   typedef enum logic [1:0] {
      TPMON_FMT_SF = 2'b00,
      TPMON_FMT_ESF = 2'b01,
      TPMON_FMT_DM = 2'b10,
      TPMON_FMT_SLC = 2'b11
   } tpmon_format_t;
endpackage

// ==== hw/tpmon_top.sv ====
// t1/j1 performance monitor: event counters, snapshots, indirect access and overflow interrupt
//
// Design decision made here: the plain strobed port.
`include "tpmon_cfg.svh"
module tpmon_top #(
   parameter int unsigned PERIOD_CYC = `TPMON_PERIOD_CYC
) (
   input wire logic clk_sys_in, // system clock 40 mhz
   input wire logic arst_n_in, // async reset, active low
   input wire logic [7:0] reg_addr_in, // register address
   input wire logic [7:0] reg_wdata_in, // register write data
   input wire logic reg_wr_in, // write strobe
   input wire logic reg_rd_in, // read strobe
   output logic [7:0] reg_rdata_out, // read data, cycle after strobe
   input wire logic line_violation_in, // line code violation event
   input wire logic framing_error_in, // f-bit / alignment bit error event
   input wire logic crc_error_in, // crc-6 error event
   input wire logic alignment_change_in, // new f-bit position event
   input wire logic sync_loss_in, // out of sync event
   input wire logic pattern_error_in, // pattern receiver bit error event
   input wire logic dds_error_in, // dds pattern error event
   output logic irq_out // level interrupt, active high
);
   localparam logic [31:0] PERIOD_MAX = 32'(PERIOD_CYC - 1);

   // event inputs come from logic on this clock, so they are read directly
   logic [3:0] index_ff;
   logic auto_update_enable_ff;
   logic manual_update_trigger_ff;
   logic [1:0] format_ff;
   logic j1_mode_ff;
   logic [5:0] ien_lo_ff;
   logic ien_hi_ff;
   logic [5:0] flg_lo_ff;
   logic flg_hi_ff;
   logic [31:0] sec_cnt_ff;
   logic snap;
   // live counters, cleared on every snapshot
   logic [15:0] lcv_ff;
   logic [11:0] fer_ff;
   logic [9:0] crc_ff;
   logic [2:0] alignment_change_count_ff;
   logic [4:0] oof_ff;
   logic [15:0] pattern_receiver_error_count_ff;
   logic [9:0] dds_ff;
   // snapshot copies, the only values software can read
   logic [15:0] lcv_snap_ff;
   logic [11:0] fer_snap_ff;
   logic [9:0] crc_snap_ff;
   logic [2:0] alignment_change_count_snap_ff;
   logic [4:0] oof_snap_ff;
   logic [15:0] pattern_receiver_error_count_snap_ff;
   logic [9:0] dds_snap_ff;
   logic [7:0] nxt_rdata;
   logic [6:0] ovf;
   logic fmt_esf;
   logic fmt_dm;
   logic fmt_t1only_ok;
   logic [7:0] snap_byte;

   // saturating counter step: clear on snapshot but keep a coincident event
   function automatic logic [15:0] cnt_next(input logic [15:0] cur, input logic [15:0] max,
                                            input logic ev, input logic clr);
      logic [15:0] base;
      base = clr ? 16'h0000 : cur;
      if (ev && base != max) begin
         cnt_next = base + 16'h0001;
      end else begin
         cnt_next = base;
      end
   endfunction

   function automatic logic at_max(input logic [15:0] cur, input logic [15:0] max, input logic ev);
      at_max = ev && (cur == max);
   endfunction

   logic wr_ctrl;
   assign wr_ctrl = reg_wr_in && reg_addr_in == `TPMON_OFF_CTRL;

   assign fmt_esf = format_ff == tpmon_pkg::TPMON_FMT_ESF;
   // j1 mode cannot select dm or subscriber_loop_carrier_format; they are treated as superframe
   assign fmt_t1only_ok = !j1_mode_ff;
   assign fmt_dm = (format_ff == tpmon_pkg::TPMON_FMT_DM) && fmt_t1only_ok;

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         index_ff <= 4'h0;
      end else if (reg_wr_in && reg_addr_in == `TPMON_OFF_INDEX) begin
         index_ff <= reg_wdata_in[3:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         auto_update_enable_ff <= 1'b0;
         manual_update_trigger_ff <= 1'b0;
      end else if (wr_ctrl) begin
         auto_update_enable_ff <= reg_wdata_in[`TPMON_CTRL_AUTO];
         manual_update_trigger_ff <= reg_wdata_in[`TPMON_CTRL_MANUAL];
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         format_ff <= 2'b00;
         j1_mode_ff <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == `TPMON_OFF_FORMAT) begin
         format_ff <= reg_wdata_in[1:0];
         j1_mode_ff <= reg_wdata_in[`TPMON_FMT_J1];
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ien_lo_ff <= 6'h00;
         ien_hi_ff <= 1'b0;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `TPMON_OFF_IEN_LO) begin
            ien_lo_ff <= reg_wdata_in[5:0];
         end
         if (reg_addr_in == `TPMON_OFF_IEN_HI) begin
            ien_hi_ff <= reg_wdata_in[`TPMON_BIT_LCV];
         end
      end
   end

   // one second timer; restarts on any snapshot so intervals stay a full second
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sec_cnt_ff <= 32'h0000_0000;
      end else if (snap || !auto_update_enable_ff) begin
         sec_cnt_ff <= 32'h0000_0000;
      end else begin
         sec_cnt_ff <= sec_cnt_ff + 32'h0000_0001;
      end
   end

   assign snap = (auto_update_enable_ff && sec_cnt_ff == PERIOD_MAX)
               || (wr_ctrl && reg_wdata_in[`TPMON_CTRL_MANUAL] && !manual_update_trigger_ff);

   // coincident event kept
   // a coincident event lands in the new interval, so the snapshot stays exact

   // line violations
   // counts in every format
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lcv_ff <= 16'h0000;
      end else begin
         lcv_ff <= cnt_next(lcv_ff, 16'hFFFF, line_violation_in, snap);
      end
   end

   // framing errors
   // f-bit or alignment bit errors, by format
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fer_ff <= 12'h000;
      end else begin
         fer_ff <= 12'(cnt_next({4'h0, fer_ff}, 16'h0FFF, framing_error_in, snap));
      end
   end

   // crc esf only
   // other formats carry no crc, so stray pulses are ignored
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         crc_ff <= 10'h000;
      end else begin
         crc_ff <= 10'(cnt_next({6'h00, crc_ff}, 16'h03FF, crc_error_in && fmt_esf, snap));
      end
   end

   // alignment changes
   // small counter, saturates quickly by design
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         alignment_change_count_ff <= 3'h0;
      end else begin
         alignment_change_count_ff <= 3'(cnt_next({13'h0000, alignment_change_count_ff}, 16'h0007, alignment_change_in, snap));
      end
   end

   // sync losses
   // one count per loss, the source pulses once
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oof_ff <= 5'h00;
      end else begin
         oof_ff <= 5'(cnt_next({11'h000, oof_ff}, 16'h001F, sync_loss_in, snap));
      end
   end

   // pattern errors
   // counts in every format
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pattern_receiver_error_count_ff <= 16'h0000;
      end else begin
         pattern_receiver_error_count_ff <= cnt_next(pattern_receiver_error_count_ff, 16'hFFFF, pattern_error_in, snap);
      end
   end

   // dds dm only
   // gated off in j1 mode, where dm does not exist
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dds_ff <= 10'h000;
      end else begin
         dds_ff <= 10'(cnt_next({6'h00, dds_ff}, 16'h03FF, dds_error_in && fmt_dm, snap));
      end
   end

   // snapshot copies take the value before the clearing edge
   // line violation copy
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lcv_snap_ff <= 16'h0000;
      end else if (snap) begin
         lcv_snap_ff <= lcv_ff;
      end
   end

   // framing error copy
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fer_snap_ff <= 12'h000;
      end else if (snap) begin
         fer_snap_ff <= fer_ff;
      end
   end

   // crc copy
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         crc_snap_ff <= 10'h000;
      end else if (snap) begin
         crc_snap_ff <= crc_ff;
      end
   end

   // alignment change copy
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         alignment_change_count_snap_ff <= 3'h0;
      end else if (snap) begin
         alignment_change_count_snap_ff <= alignment_change_count_ff;
      end
   end

   // sync loss copy
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oof_snap_ff <= 5'h00;
      end else if (snap) begin
         oof_snap_ff <= oof_ff;
      end
   end

   // pattern error copy
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pattern_receiver_error_count_snap_ff <= 16'h0000;
      end else if (snap) begin
         pattern_receiver_error_count_snap_ff <= pattern_receiver_error_count_ff;
      end
   end

   // dds copy
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dds_snap_ff <= 10'h000;
      end else if (snap) begin
         dds_snap_ff <= dds_ff;
      end
   end

   assign ovf[`TPMON_BIT_FER] = at_max({4'h0, fer_ff}, 16'h0FFF, framing_error_in) && !snap;
   assign ovf[`TPMON_BIT_CRC] = at_max({6'h00, crc_ff}, 16'h03FF, crc_error_in && fmt_esf) && !snap;
   assign ovf[`TPMON_BIT_ALIGNMENT_CHANGE_COUNT] = at_max({13'h0000, alignment_change_count_ff}, 16'h0007, alignment_change_in) && !snap;
   assign ovf[`TPMON_BIT_OOF] = at_max({11'h000, oof_ff}, 16'h001F, sync_loss_in) && !snap;
   assign ovf[`TPMON_BIT_PATTERN_RECEIVER_ERROR_COUNT] = at_max(pattern_receiver_error_count_ff, 16'hFFFF, pattern_error_in) && !snap;
   assign ovf[`TPMON_BIT_DDS] = at_max({6'h00, dds_ff}, 16'h03FF, dds_error_in && fmt_dm) && !snap;
   assign ovf[6] = at_max(lcv_ff, 16'hFFFF, line_violation_in) && !snap;

   // sticky overflow flags, read clears, set wins
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flg_lo_ff <= 6'h00;
         flg_hi_ff <= 1'b0;
      end else begin
         flg_lo_ff <= ((reg_rd_in && reg_addr_in == `TPMON_OFF_FLG_LO) ? 6'h00 : flg_lo_ff) | ovf[5:0];
         flg_hi_ff <= ((reg_rd_in && reg_addr_in == `TPMON_OFF_FLG_HI) ? 1'b0 : flg_hi_ff) | ovf[6];
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(flg_lo_ff & ien_lo_ff) || (flg_hi_ff && ien_hi_ff);
      end
   end

   always_comb begin
      snap_byte = `TPMON_RESET_BYTE;
      unique case (index_ff)
         `TPMON_ID_CRC_LO: snap_byte = crc_snap_ff[7:0];
         `TPMON_ID_CRC_HI: snap_byte = {6'h00, crc_snap_ff[9:8]};
         `TPMON_ID_FER_LO: snap_byte = fer_snap_ff[7:0];
         `TPMON_ID_FER_HI: snap_byte = {4'h0, fer_snap_ff[11:8]};
         `TPMON_ID_ALIGNMENT_CHANGE_COUNT: snap_byte = {5'h00, alignment_change_count_snap_ff};
         `TPMON_ID_OOF: snap_byte = {3'h0, oof_snap_ff};
         `TPMON_ID_PATTERN_RECEIVER_ERROR_COUNT_LO: snap_byte = pattern_receiver_error_count_snap_ff[7:0];
         `TPMON_ID_PATTERN_RECEIVER_ERROR_COUNT_HI: snap_byte = pattern_receiver_error_count_snap_ff[15:8];
         `TPMON_ID_LCV_LO: snap_byte = lcv_snap_ff[7:0];
         `TPMON_ID_LCV_HI: snap_byte = lcv_snap_ff[15:8];
         `TPMON_ID_DDS_LO: snap_byte = dds_snap_ff[7:0];
         `TPMON_ID_DDS_HI: snap_byte = {6'h00, dds_snap_ff[9:8]};
         default: snap_byte = `TPMON_RESET_BYTE;
      endcase
   end

   always_comb begin
      nxt_rdata = `TPMON_RESET_BYTE;
      unique case (reg_addr_in)
         `TPMON_OFF_INDEX: nxt_rdata = {4'h0, index_ff};
         `TPMON_OFF_DATA: nxt_rdata = snap_byte;
         `TPMON_OFF_CTRL: nxt_rdata = {6'h00, manual_update_trigger_ff, auto_update_enable_ff};
         `TPMON_OFF_IEN_LO: nxt_rdata = {2'h0, ien_lo_ff};
         `TPMON_OFF_IEN_HI: nxt_rdata = {7'h00, ien_hi_ff};
         `TPMON_OFF_FLG_LO: nxt_rdata = {2'h0, flg_lo_ff};
         `TPMON_OFF_FLG_HI: nxt_rdata = {7'h00, flg_hi_ff};
         `TPMON_OFF_STATUS: nxt_rdata = {7'h00, irq_out};
         `TPMON_OFF_FORMAT: nxt_rdata = {5'h00, j1_mode_ff, format_ff};
         default: nxt_rdata = `TPMON_RESET_BYTE;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= nxt_rdata;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end
endmodule // tpmon_top

// ==== verif/tpmon_assertions.sv ====
// port checks of the performance monitor, bound into its top
module tpmon_assertions #(
   parameter int unsigned PERIOD_CYC = 50 // snapshot period
) (
   input wire logic clk_sys_in, // clock
   input wire logic arst_n_in, // reset
   input wire logic [7:0] reg_addr_in, // address
   input wire logic [7:0] reg_wdata_in, // write data
   input wire logic reg_wr_in, // write strobe
   input wire logic reg_rd_in, // read strobe
   input wire logic [7:0] reg_rdata_out, // read data
   input wire logic irq_out // interrupt
);
   // enables shadowed from writes, so irq is tied to what software allowed
   logic [6:0] ien_ff;
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
      if (!arst_n_in) ien_ff <= 7'h00;
      else if (reg_wr_in && reg_addr_in == 8'hC3) ien_ff[5:0] <= reg_wdata_in[5:0];
      else if (reg_wr_in && reg_addr_in == 8'hC4) ien_ff[6] <= reg_wdata_in[0];
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   property p_rb(logic [7:0] a, logic [7:0] m);
      reg_wr_in && reg_addr_in == a ##1 !reg_wr_in ##1 reg_rd_in && reg_addr_in == a
         |=> (reg_rdata_out & m) == ($past(reg_wdata_in, 3) & m);
   endproperty
   a_index_back: assert property (p_rb(8'h0E, 8'h0F)) else $error("index readback");
   a_ctrl_back: assert property (p_rb(8'hC2, 8'h03)) else $error("control readback");
   a_ien_lo_back: assert property (p_rb(8'hC3, 8'h3F)) else $error("enable readback");
   a_ien_hi_back: assert property (p_rb(8'hC4, 8'h01)) else $error("enable readback");
   a_format_back: assert property (p_rb(8'hC8, 8'h07)) else $error("format readback");
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("stray data");
   a_unmapped_zero: assert property (reg_rd_in && !(reg_addr_in inside {8'h0E, 8'h0F, [8'hC2:8'hC8]})
      |=> reg_rdata_out == 8'h00) else $error("unmapped data");
   a_irq_enabled: assert property (irq_out |-> $past(ien_ff) != 7'h00) else $error("irq while masked");
   c_manual: cover property (reg_wr_in && reg_addr_in == 8'hC2 && reg_wdata_in[1]);
   c_irq: cover property ($rose(irq_out));
   c_flags: cover property (reg_rd_in && reg_addr_in == 8'hC5 ##1 reg_rdata_out != 8'h00);
endmodule // tpmon_assertions
bind tpmon_top tpmon_assertions #(.PERIOD_CYC(PERIOD_CYC)) i_tpmon_assertions (.clk_sys_in, .arst_n_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out);

// ==== verif/tpmon_event_src.sv ====
// event source model: pulses chosen event lines a set number of times
module tpmon_event_src (
   input wire logic clk_sys_in, // clock
   input wire logic arst_n_in, // reset
   input wire logic go_in, // start burst
   input wire logic slow_in, // every other cycle
   input wire logic [6:0] mask_in, // lines to pulse
   input wire logic [7:0] len_in, // pulses per line
   output logic [6:0] ev_out, // event pulses
   output logic busy_out // burst running
);
   logic [7:0] left_ff;
   logic gap_ff;
   logic [6:0] mask_ff;
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
      if (!arst_n_in) {left_ff, gap_ff, mask_ff} <= 16'h0000;
      else if (go_in) {left_ff, gap_ff, mask_ff} <= {len_in, 1'b0, mask_in};
      else if (busy_out) {left_ff, gap_ff} <= gap_ff ? {left_ff, 1'b0} : {left_ff - 8'h01, slow_in};
   assign busy_out = left_ff != 8'h00;
   // lines drop between pulses only with slow_in set; without it the level is held for len_in cycles and counted every cycle
   assign ev_out = (busy_out && !gap_ff) ? mask_ff : 7'h00;
endmodule // tpmon_event_src

// ==== verif/tpmon_top_test.sv ====
// bench of the performance monitor
module tpmon_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in, arst_n_in, wr, rd, go, slow, irq, busy;
   logic [7:0] addr, wdata, rdata, len, d, a;
   logic [6:0] ev, mask;
   int failures = 0, tests_run = 0, cyc = 0;
   tpmon_top #(.PERIOD_CYC(50)) i_tpmon_top (.clk_sys_in, .arst_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .line_violation_in(ev[0]), .framing_error_in(ev[1]),
      .crc_error_in(ev[2]), .alignment_change_in(ev[3]), .sync_loss_in(ev[4]), .pattern_error_in(ev[5]),
      .dds_error_in(ev[6]), .irq_out(irq));
   tpmon_event_src i_tpmon_event_src (.clk_sys_in, .arst_n_in, .go_in(go), .slow_in(slow), .mask_in(mask),
      .len_in(len), .ev_out(ev), .busy_out(busy));
   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // idle cycle after a write keeps the strobe from being set twice in one step
   task automatic wr_reg(input logic [7:0] ad, input logic [7:0] v);
      {addr, wdata, wr} <= {ad, v, 1'b1};
      @(posedge clk_sys_in);
      wr <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic rd_reg(input logic [7:0] ad, output logic [7:0] v);
      {addr, rd} <= {ad, 1'b1};
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 v = rdata;
      @(posedge clk_sys_in);
   endtask
   task automatic rdi(input logic [7:0] i, output logic [7:0] v);
      wr_reg(8'h0E, i);
      rd_reg(8'h0F, v);
   endtask
   task automatic snap();
      wr_reg(8'hC2, 8'h00);
      wr_reg(8'hC2, 8'h02);
   endtask
   task automatic burst(input logic [6:0] m, input logic [7:0] n, input logic s, input logic w);
      {mask, len, slow, go} <= {m, n, s, 1'b1};
      @(posedge clk_sys_in);
      go <= 1'b0;
      for (int k = 0; w && k < 400 && (k == 0 || busy === 1'b1); k++) begin
         @(posedge clk_sys_in);
         #1;
      end
      @(posedge clk_sys_in);
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      {arst_n_in, wr, rd, go, slow, addr, wdata, mask, len} = 36'h0;
      repeat (10) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      burst(7'h7F, 8'h03, 1'b1, 1'b1);
      snap(); // manual copy
      rd_reg(8'hC2, d);
      chk("ctrl", 8'h02, d); // trigger bit stored
      for (int i = 0; i < 16; i++) begin
         rdi(i[7:0], d);
         chk("snap", ((16'h0174 >> i) & 16'h0001) ? 8'h03 : 8'h00, d); // byte map
      end
      snap();
      rdi(8'h08, d);
      chk("clr", 8'h00, d); // fresh interval
      wr_reg(8'h0E, 8'h0B);
      rd_reg(8'h0E, d);
      chk("index", 8'h0B, d); // index readback
      rd_reg(8'h10, d);
      chk("unmap", 8'h00, d); // unmapped place
      $display("test map done");
      for (int f = 0; f < 5; f++) begin
         a = (f == 4) ? 8'h06 : f[7:0];
         wr_reg(8'hC8, a);
         rd_reg(8'hC8, d);
         chk("format", a, d); // format readback
         burst(7'h44, 8'h02, 1'b0, 1'b1);
         snap();
         rdi(8'h00, d);
         chk("crc", f == 1 ? 8'h02 : 8'h00, d); // esf only
         rdi(8'h0A, d);
         chk("dds", f == 2 ? 8'h02 : 8'h00, d); // digital_multiplexed_format only
      end
      $display("test formats done");
      // copy lands inside an unbroken event run
      burst(7'h01, 8'h0A, 1'b0, 1'b0);
      snap();
      rdi(8'h08, a);
      #1;
      while (busy === 1'b1) begin
         @(posedge clk_sys_in);
         #1;
      end
      @(posedge clk_sys_in);
      snap();
      rdi(8'h08, d);
      chk("sum", 8'h0A, a + d); // nothing lost
      wr_reg(8'hC2, 8'h01);
      burst(7'h01, 8'h07, 1'b0, 1'b1);
      repeat (45) @(posedge clk_sys_in);
      rdi(8'h08, d);
      chk("auto", 8'h07, d); // periodic copy
      wr_reg(8'hC2, 8'h00);
      $display("test updates done");
      wr_reg(8'hC3, 8'h04);
      rd_reg(8'hC3, d);
      chk("ien", 8'h04, d); // low enables
      wr_reg(8'hC4, 8'h01);
      rd_reg(8'hC4, d);
      chk("ien", 8'h01, d); // line violation enable
      burst(7'h18, 8'h21, 1'b0, 1'b1);
      chk("irq", 8'h01, {7'h00, irq}); // enabled overflow
      rd_reg(8'hC5, d);
      chk("flg", 8'h0C, d); // overflow flags
      rd_reg(8'hC5, d);
      chk("flg", 8'h00, d); // cleared by read
      chk("irq", 8'h00, {7'h00, irq}); // interrupt drops
      snap();
      rdi(8'h04, d);
      chk("sat", 8'h07, d); // held at top
      rdi(8'h05, d);
      chk("sat", 8'h1F, d); // held at top
      $display("test overflow done");
      stop_test();
   end
endmodule // tpmon_top_test
